// ---- hw/sqdc_top.sv ----
// squib arming, deployment and diagnostic switch control
// Functional notes
// - one pulse stretch timer per channel, two sources
// - arming uses its own byte-wide serial port
// - arming chip select end latches bits, starts timers
// - deploy needs enable pin plus crossed timer source
// - deploy drives both sides fixed time, unstoppable
// - deploy enable starts timer at chip select fall
// - same-source enable reloads a running timer
// - deploy disable stops only deploy-started timer
// - arming enable starts; arming disable stops own only
// - arming commands ignored during any deployment
// - register and diagnostic messages faulted during deploy
// - command mode skips deploying channels during deploy
// - monitor runs for all, reply next transfer
// - enable pin permits drivers, cannot abort deploy
// - enable low: MOS check drivers off, diagnostics still run
// - enable low blocks deploy start, status still reports
// - arming starts timer regardless of enable pin
// - enable pin changes never touch running timers
// - enable pin passes through de-glitch filter
// - serial command switches sources and sinks; pulldown follows bias
// - source channel independent of monitored channel
// - continuity diagnostic turns bias on selected channel
// - driver transfer not sixteen clocks is faulted
// - arming transfer not multiple of eight discarded
// - top two bits pick driver message mode
`timescale 1ns/1ps
module sqdc_top
  import sqdc_pkg::*;
#(
  parameter int DEPLOY_CYCLES = sqdc_pkg::SQDC_DEPLOY_CYC,
  parameter int PST_CYCLES = sqdc_pkg::SQDC_PST_CYC,
  parameter int GLITCH_CYCLES = sqdc_pkg::SQDC_GLITCH_CYC,
  parameter int MOS_CYCLES = sqdc_pkg::SQDC_MOS_CYC
) (
  input wire logic core_clk_i,                     // 20 MHz core clock
  input wire logic rst_i,                          // async reset, high
  input wire logic sclk_a_i,                       // arming port bit clock
  input wire logic cs_a_i,                         // arming port select, high
  input wire logic mosi_a_i,                       // arming port data in
  output logic miso_a_o,                           // arming port data out
  output logic miso_a_oe_o,                        // arming data out enable
  input wire logic sclk_i,                         // driver port bit clock
  input wire logic cs_d_i,                         // driver port select, high
  input wire logic mosi_i,                         // driver port data in
  output logic miso_o,                             // driver port data out
  output logic miso_oe_o,                          // driver data out enable
  input wire logic deploy_enable_pin_i,            // deploy enable pin
  input wire logic [sqdc_pkg::SQDC_NCH-1:0] battery_short_threshold_i, // sqh above threshold
  input wire logic [sqdc_pkg::SQDC_NCH-1:0] ground_short_threshold_i, // sql below threshold
  output logic [sqdc_pkg::SQDC_NCH-1:0] high_side_output_o, // high side driver on
  output logic [sqdc_pkg::SQDC_NCH-1:0] low_side_output_o, // low side driver on
  output logic [sqdc_pkg::SQDC_NCH-1:0] isrc_en_o, // source current on
  output logic [sqdc_pkg::SQDC_NCH-1:0] isink_en_o, // sink current on
  output logic [sqdc_pkg::SQDC_NCH-1:0] ibias_en_o, // bias current on
  output logic [sqdc_pkg::SQDC_NCH-1:0] high_side_pulldown_o, // sqh pulldown on
  output logic [2:0] monitor_sel_o                 // monitored channel
);
  import sqdc_pkg::*;

  localparam int NS = 7 + 2 * SQDC_NCH;
  typedef enum logic [1:0] {SQDC_MOS_IDLE, SQDC_MOS_LOW, SQDC_MOS_HIGH} sqdc_mos_t;

  // two-stage synchronisers for every pin
  logic [NS-1:0] sync1_q, sync2_q;
  logic sclk_a_prev_q, cs_a_prev_q, sclk_prev_q, cs_d_prev_q;
  logic s_sclk_a, s_cs_a, s_mosi_a, s_sclk, s_cs_d, s_mosi, s_den;
  logic [SQDC_NCH-1:0] s_batt, s_gnd;
  logic den_f;

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else
    begin
      sync1_q <= {ground_short_threshold_i, battery_short_threshold_i, deploy_enable_pin_i,
                  mosi_i, cs_d_i, sclk_i, mosi_a_i, cs_a_i, sclk_a_i};
      sync2_q <= sync1_q;
    end
  end

  assign {s_gnd, s_batt, s_den, s_mosi, s_cs_d, s_sclk, s_mosi_a, s_cs_a, s_sclk_a} = sync2_q;

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sclk_a_prev_q <= 1'b0;
      cs_a_prev_q <= 1'b0;
      sclk_prev_q <= 1'b0;
      cs_d_prev_q <= 1'b0;
    end
    else
    begin
      sclk_a_prev_q <= s_sclk_a;
      cs_a_prev_q <= s_cs_a;
      sclk_prev_q <= s_sclk;
      cs_d_prev_q <= s_cs_d;
    end
  end

  sqdc_deglitch #(.CYCLES(GLITCH_CYCLES)) u_den_filter (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .in_i(s_den),
    .out_o(den_f)
  );

  logic a_start, a_end, a_rise, a_fall, d_start, d_end, d_rise, d_fall;
  assign a_start = s_cs_a & ~cs_a_prev_q;
  assign a_end = ~s_cs_a & cs_a_prev_q;
  assign a_rise = s_cs_a & s_sclk_a & ~sclk_a_prev_q;
  assign a_fall = s_cs_a & ~s_sclk_a & sclk_a_prev_q;
  assign d_start = s_cs_d & ~cs_d_prev_q;
  assign d_end = ~s_cs_d & cs_d_prev_q;
  assign d_rise = s_cs_d & s_sclk & ~sclk_prev_q;
  assign d_fall = s_cs_d & ~s_sclk & sclk_prev_q;

  // per-channel state
  logic [SQDC_NCH-1:0] pst_busy, pst_load, pst_stop, pst_src_dep_q, pst_src_dep_d;
  logic [SQDC_NCH-1:0] dep_busy, fire, deployed_q;
  logic deploying;
  assign deploying = |dep_busy;

  genvar g;
  generate
    for (g = 0; g < SQDC_NCH; g++)
    begin : g_ch
      sqdc_timer #(.CYCLES(PST_CYCLES)) u_pst (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .load_i(pst_load[g]),
        .stop_i(pst_stop[g]),
        .busy_o(pst_busy[g])
      );
      sqdc_timer #(.CYCLES(DEPLOY_CYCLES)) u_deploy (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .load_i(fire[g]),
        .stop_i(1'b0),
        .busy_o(dep_busy[g])
      );
    end
  endgenerate

  // arming port: byte shift register doubles as daisy-chain pass-through
  logic [SQDC_ARM_BITS-1:0] arm_sr_q;
  logic [2:0] arm_cnt_q;
  logic arm_any_q, arm_latch;

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      arm_sr_q <= '0;
      arm_cnt_q <= '0;
      arm_any_q <= 1'b0;
      miso_a_o <= 1'b0;
    end
    else if (a_start)
    begin
      arm_sr_q <= pst_busy & ~pst_src_dep_q;
      arm_cnt_q <= '0;
      arm_any_q <= 1'b0;
      miso_a_o <= pst_busy[SQDC_NCH-1] & ~pst_src_dep_q[SQDC_NCH-1];
    end
    else if (a_rise)
    begin
      arm_sr_q <= {arm_sr_q[SQDC_ARM_BITS-2:0], s_mosi_a};
      arm_cnt_q <= arm_cnt_q + 3'h1;
      arm_any_q <= 1'b1;
    end
    else if (a_fall)
      miso_a_o <= arm_sr_q[SQDC_ARM_BITS-1];
  end

  assign miso_a_oe_o = s_cs_a;
  // whole bytes only, and nothing during a deployment
  assign arm_latch = a_end & arm_any_q & (arm_cnt_q == 3'h0) & ~deploying;

  // driver port receive, count and transmit
  logic [SQDC_DRV_BITS-1:0] drv_sr_q, tx_q, resp_q, resp_d;
  logic [4:0] drv_cnt_q;
  logic drv_ok;

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      drv_sr_q <= '0;
      drv_cnt_q <= '0;
      tx_q <= '0;
      miso_o <= 1'b0;
    end
    else if (d_start)
    begin
      drv_cnt_q <= '0;
      tx_q <= resp_q;
      miso_o <= resp_q[SQDC_DRV_BITS-1];
    end
    else if (d_rise)
    begin
      drv_sr_q <= {drv_sr_q[SQDC_DRV_BITS-2:0], s_mosi};
      if (drv_cnt_q != 5'h11)
        drv_cnt_q <= drv_cnt_q + 5'h1;
    end
    else if (d_fall)
    begin
      tx_q <= {tx_q[SQDC_DRV_BITS-2:0], 1'b0};
      miso_o <= tx_q[SQDC_DRV_BITS-2];
    end
  end

  assign miso_oe_o = s_cs_d;
  assign drv_ok = d_end & (drv_cnt_q == 5'(SQDC_DRV_BITS));

  logic [1:0] mode;
  logic cmd_go, diag_go, reg_go, mon_go;
  assign mode = drv_sr_q[SQDC_MODE_MSB:SQDC_MODE_LSB];
  assign cmd_go = drv_ok & (mode == SQDC_MODE_CMD);
  assign diag_go = drv_ok & (mode == SQDC_MODE_DIAG) & ~deploying;
  assign reg_go = drv_ok & (mode == SQDC_MODE_REG) & ~deploying;
  assign mon_go = drv_ok & (mode == SQDC_MODE_MON);

  // timer start, reload, stop and deployment trigger per channel
  always_comb
  begin
    pst_load = '0;
    pst_stop = '0;
    fire = '0;
    pst_src_dep_d = pst_src_dep_q;
    for (int c = 0; c < SQDC_NCH; c++)
    begin
      if (arm_latch)
      begin
        if (arm_sr_q[c])
        begin
          if (pst_busy[c] && pst_src_dep_q[c])
          begin
            if (den_f && !dep_busy[c])
              fire[c] = 1'b1;
          end
          else
          begin
            pst_load[c] = 1'b1;
            pst_src_dep_d[c] = 1'b0;
          end
        end
        else if (pst_busy[c] && !pst_src_dep_q[c])
          pst_stop[c] = 1'b1;
      end
      // deploying channel untouched by command mode
      if (cmd_go && !dep_busy[c])
      begin
        if (drv_sr_q[c] && drv_sr_q[SQDC_CMD_EN_BIT] && den_f)
        begin
          if (pst_busy[c] && !pst_src_dep_q[c])
            fire[c] = 1'b1;
          else if (!pst_load[c])
          begin
            pst_load[c] = 1'b1;
            pst_src_dep_d[c] = 1'b1;
          end
        end
        else if (drv_sr_q[c] && !drv_sr_q[SQDC_CMD_EN_BIT] && pst_busy[c] && pst_src_dep_q[c])
          pst_stop[c] = 1'b1;
      end
      // a started deployment consumes the timer
      if (fire[c])
      begin
        pst_load[c] = 1'b0;
        pst_stop[c] = 1'b1;
      end
    end
  end

  // pst_busy falls at expiry, after which no command can fire
  // den_f is read when firing and when command mode starts a timer, never to stop one
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pst_src_dep_q <= '0;
      deployed_q <= '0;
    end
    else
    begin
      pst_src_dep_q <= pst_src_dep_d;
      deployed_q <= deployed_q | fire;
    end
  end

  // diagnostic switches and MOS check
  logic [2:0] src_ch, mos_ch_q;
  logic [SQDC_NCH-1:0] onehot;
  logic mos_busy, mos_load, mos_stop, diag_fail_q, pre_bad;
  sqdc_mos_t mos_st_q;

  assign src_ch = drv_sr_q[SQDC_SRC_CH_MSB:SQDC_SRC_CH_LSB];
  assign onehot = SQDC_NCH'(1) << src_ch;
  assign pre_bad = s_batt[src_ch] | s_gnd[src_ch];

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      isrc_en_o <= '0;
      isink_en_o <= '0;
      ibias_en_o <= '0;
      monitor_sel_o <= '0;
    end
    else if (diag_go)
    begin
      isrc_en_o <= drv_sr_q[SQDC_ISRC_BIT] ? onehot : '0;
      isink_en_o <= drv_sr_q[SQDC_ISINK_BIT] ? onehot : '0;
      ibias_en_o <= (drv_sr_q[SQDC_IBIAS_BIT] | drv_sr_q[SQDC_CONT_BIT]) ? onehot : '0;
      monitor_sel_o <= drv_sr_q[SQDC_MON_CH_MSB:SQDC_MON_CH_LSB];
    end
  end

  assign high_side_pulldown_o = ibias_en_o;

  assign mos_load = diag_go & (drv_sr_q[SQDC_MOS_LO_BIT] | drv_sr_q[SQDC_MOS_HI_BIT]) & ~pre_bad;
  assign mos_stop = (mos_st_q != SQDC_MOS_IDLE) & (s_batt[mos_ch_q] | s_gnd[mos_ch_q]);

  sqdc_timer #(.CYCLES(MOS_CYCLES)) u_mos (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .load_i(mos_load),
    .stop_i(mos_stop),
    .busy_o(mos_busy)
  );

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      mos_st_q <= SQDC_MOS_IDLE;
      mos_ch_q <= '0;
      diag_fail_q <= 1'b0;
    end
    else if (diag_go)
    begin
      mos_ch_q <= src_ch;
      diag_fail_q <= (drv_sr_q[SQDC_MOS_LO_BIT] | drv_sr_q[SQDC_MOS_HI_BIT]) & pre_bad;
      if (mos_load)
        mos_st_q <= drv_sr_q[SQDC_MOS_LO_BIT] ? SQDC_MOS_LOW : SQDC_MOS_HIGH;
      else
        mos_st_q <= SQDC_MOS_IDLE;
    end
    else if (!mos_busy && !mos_load)
      mos_st_q <= SQDC_MOS_IDLE;
  end

  // drivers: deployment ignores the enable pin once begun, diagnostics need it
  always_comb
  begin
    high_side_output_o = dep_busy;
    low_side_output_o = dep_busy;
    if (den_f && mos_busy)
    begin
      unique case (mos_st_q)
        SQDC_MOS_LOW: low_side_output_o[mos_ch_q] = 1'b1;
        SQDC_MOS_HIGH: high_side_output_o[mos_ch_q] = 1'b1;
        SQDC_MOS_IDLE: ;
      endcase
    end
  end

  // reply for the next transfer
  always_comb
  begin
    resp_d = resp_q;
    if (d_end)
    begin
      if (!drv_ok)
        resp_d = SQDC_RESP_FAULT;
      else
      begin
        unique case (mode)
          SQDC_MODE_REG: resp_d = deploying ? SQDC_RESP_FAULT
                                 : {SQDC_HDR_REG, 5'h0, deployed_q};
          SQDC_MODE_CMD: resp_d = {SQDC_HDR_CMD, 5'h0, drv_sr_q[7:0]};
          SQDC_MODE_DIAG: resp_d = deploying ? SQDC_RESP_FAULT
                                  : {SQDC_HDR_DIAG, diag_fail_q, 5'h0,
                                     s_batt[monitor_sel_o], s_gnd[monitor_sel_o], 6'h0};
          SQDC_MODE_MON: resp_d = {SQDC_HDR_STAT, 5'h0, dep_busy};
        endcase
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      resp_q <= SQDC_RESP_RST;
    else
      resp_q <= resp_d;
  end
endmodule

// ---- hw/sqdc_pkg.sv ----
// constants shared by the squib arming and deploy control block
package sqdc_pkg;
  localparam int SQDC_NCH = 8;
  localparam int SQDC_CLK_HZ = 20000000;
  localparam int SQDC_CYC_PER_US = SQDC_CLK_HZ / 1000000;
  // timing figures in microseconds and derived cycle counts
  localparam int SQDC_DEPLOY_US = 2000;
  localparam int SQDC_DEPLOY_CYC = SQDC_DEPLOY_US * SQDC_CYC_PER_US;
  localparam int SQDC_PST_US = 250000;
  localparam int SQDC_PST_CYC = SQDC_PST_US * SQDC_CYC_PER_US;
  localparam int SQDC_GLITCH_US = 10;
  localparam int SQDC_GLITCH_CYC = SQDC_GLITCH_US * SQDC_CYC_PER_US;
  localparam int SQDC_MOS_US = 100;
  localparam int SQDC_MOS_CYC = SQDC_MOS_US * SQDC_CYC_PER_US;
  // transfer lengths
  localparam int SQDC_DRV_BITS = 16;
  localparam int SQDC_ARM_BITS = 8;
  // driver-port word fields
  localparam int SQDC_MODE_MSB = 15;
  localparam int SQDC_MODE_LSB = 14;
  localparam logic [1:0] SQDC_MODE_REG = 2'h0;
  localparam logic [1:0] SQDC_MODE_CMD = 2'h1;
  localparam logic [1:0] SQDC_MODE_DIAG = 2'h2;
  localparam logic [1:0] SQDC_MODE_MON = 2'h3;
  localparam int SQDC_CMD_EN_BIT = 8;
  localparam int SQDC_MON_CH_MSB = 13;
  localparam int SQDC_MON_CH_LSB = 11;
  localparam int SQDC_SRC_CH_MSB = 10;
  localparam int SQDC_SRC_CH_LSB = 8;
  localparam int SQDC_CONT_BIT = 7;
  localparam int SQDC_MOS_LO_BIT = 6;
  localparam int SQDC_MOS_HI_BIT = 5;
  localparam int SQDC_ISRC_BIT = 2;
  localparam int SQDC_ISINK_BIT = 1;
  localparam int SQDC_IBIAS_BIT = 0;
  // response headers, top three bits; the diagnostic header is top two
  localparam logic [2:0] SQDC_HDR_REG = 3'h0;
  localparam logic [2:0] SQDC_HDR_CMD = 3'h2;
  localparam logic [1:0] SQDC_HDR_DIAG = 2'h2;
  localparam logic [2:0] SQDC_HDR_STAT = 3'h6;
  localparam logic [15:0] SQDC_RESP_FAULT = 16'he000;
  localparam logic [15:0] SQDC_RESP_RST = 16'h0000;
endpackage

// ---- hw/sqdc_timer.sv ----
// down-counting one-shot timer with load and stop
`timescale 1ns/1ps
module sqdc_timer #(
  parameter int CYCLES = 16
) (
  input wire logic core_clk_i, // core clock
  input wire logic rst_i,      // async reset, high
  input wire logic load_i,     // start or reload
  input wire logic stop_i,     // stop early
  output logic busy_o          // running
);
  localparam int CW = $clog2(CYCLES + 1);
  logic [CW-1:0] cnt_q;

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      cnt_q <= '0;
    else if (load_i)
      cnt_q <= CW'(CYCLES);
    else if (stop_i)
      cnt_q <= '0;
    else if (cnt_q != '0)
      cnt_q <= cnt_q - 1'b1;
  end

  // validity ends exactly when the count reaches zero
  assign busy_o = (cnt_q != '0);
endmodule

// ---- hw/sqdc_deglitch.sv ----
// level filter: output follows input only after it is stable long enough
`timescale 1ns/1ps
module sqdc_deglitch #(
  parameter int CYCLES = 16
) (
  input wire logic core_clk_i, // core clock
  input wire logic rst_i,      // async reset, high
  input wire logic in_i,       // synchronised level
  output logic out_o           // filtered level
);
  localparam int CW = $clog2(CYCLES + 1);
  logic [CW-1:0] cnt_q;

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt_q <= '0;
      out_o <= 1'b0;
    end
    else if (in_i == out_o)
      cnt_q <= '0;
    else if (cnt_q == CW'(CYCLES - 1))
    begin
      cnt_q <= '0;
      out_o <= in_i;
    end
    else
      cnt_q <= cnt_q + 1'b1;
  end
endmodule

// ---- tb/sqdc_monitor.sv ----
// checker for the squib arming and deploy control block
`timescale 1ns/1ps
module sqdc_monitor
  import sqdc_pkg::*;
#(
  parameter int DEPLOY_CYCLES = 50,
  parameter int GLITCH_CYCLES = 4
) (
  input wire logic core_clk_i, // core clock
  input wire logic rst_i, // async reset, high
  input wire logic cs_a_i, // arming select
  input wire logic cs_d_i, // driver select
  input wire logic miso_a_oe_o, // arming out enable
  input wire logic miso_oe_o, // driver out enable
  input wire logic deploy_enable_pin_i, // enable pin
  input wire logic [sqdc_pkg::SQDC_NCH-1:0] high_side_output_o, // high side on
  input wire logic [sqdc_pkg::SQDC_NCH-1:0] low_side_output_o, // low side on
  input wire logic [sqdc_pkg::SQDC_NCH-1:0] isrc_en_o, // source on
  input wire logic [sqdc_pkg::SQDC_NCH-1:0] isink_en_o, // sink on
  input wire logic [sqdc_pkg::SQDC_NCH-1:0] ibias_en_o, // bias on
  input wire logic [sqdc_pkg::SQDC_NCH-1:0] high_side_pulldown_o // pulldown on
);
  import sqdc_pkg::*;
  logic [SQDC_NCH-1:0] both;
  logic [15:0] len_q;
  logic [15:0] low_q;
  logic [7:0] since_q;
  logic cs_a_q;
  logic cs_d_q;
  assign both = high_side_output_o & low_side_output_o;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);
  // cycles channel 0 has been deploying
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      len_q <= '0;
    else
      len_q <= both[0] ? len_q + 16'h1 : 16'h0;
  end
  // cycles since a select fell, and since the pin went low
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cs_a_q <= 1'b0;
      cs_d_q <= 1'b0;
      since_q <= 8'hff;
      low_q <= '0;
    end
    else
    begin
      cs_a_q <= cs_a_i;
      cs_d_q <= cs_d_i;
      if ((cs_a_q && !cs_a_i) || (cs_d_q && !cs_d_i))
        since_q <= '0;
      else if (since_q != 8'hff)
        since_q <= since_q + 8'h1;
      if (deploy_enable_pin_i)
        low_q <= '0;
      else if (low_q != 16'hffff)
        low_q <= low_q + 16'h1;
    end
  end
  a_pulldown_bias: assert property (high_side_pulldown_o == ibias_en_o)
    else $error("pulldown differs from bias");
  a_switch_onehot: assert property ($onehot0(isrc_en_o) && $onehot0(isink_en_o)
    && $onehot0(ibias_en_o)) else $error("more than one switched channel");
  a_deploy_length: assert property ($fell(both[0]) |-> len_q == DEPLOY_CYCLES)
    else $error("deploy length wrong");
  a_deploy_held: assert property (both[0] && len_q < DEPLOY_CYCLES - 1 |=> both[0])
    else $error("deploy cut short");
  a_reset_clear: assert property ($fell(rst_i) |-> both == '0 && ibias_en_o == '0)
    else $error("outputs active after reset");
  a_start_after_cs: assert property (|(both & ~$past(both)) |-> since_q <= 8'd10)
    else $error("deploy without a transfer end");
  a_start_needs_pin: assert property (|(both & ~$past(both))
    |-> low_q < GLITCH_CYCLES + 6) else $error("deploy with pin low");
  a_arm_release: assert property ($fell(cs_a_i) |-> ##[1:4] !miso_a_oe_o)
    else $error("arming out not released");
  a_drv_drive: assert property ($rose(cs_d_i) |-> ##[1:4] miso_oe_o)
    else $error("driver out not driven");
  a_switch_cause: assert property (($changed(ibias_en_o) || $changed(isrc_en_o))
    |-> since_q <= 8'd10) else $error("switch moved without a transfer");
  c_deploy: cover property ($rose(both[0]));
  c_done: cover property ($fell(both[0]));
  c_bias: cover property (ibias_en_o != '0);
endmodule
bind sqdc_top sqdc_monitor #(.DEPLOY_CYCLES(DEPLOY_CYCLES), .GLITCH_CYCLES(GLITCH_CYCLES))
  sqdc_monitor_i (.core_clk_i, .rst_i, .cs_a_i, .cs_d_i, .miso_a_oe_o, .miso_oe_o,
  .deploy_enable_pin_i, .high_side_output_o, .low_side_output_o, .isrc_en_o, .isink_en_o,
  .ibias_en_o, .high_side_pulldown_o);

// ---- tb/sqdc_host.sv ----
// host model: serial master on the arming and driver ports
`timescale 1ns/1ps
module sqdc_host (
  input wire logic core_clk_i, // core clock
  input wire logic miso_a_i, // arming reply line
  input wire logic miso_i, // driver reply line
  output logic sclk_a_o, // arming bit clock
  output logic cs_a_o, // arming select
  output logic mosi_a_o, // arming data
  output logic sclk_o, // driver bit clock
  output logic cs_d_o, // driver select
  output logic mosi_o // driver data
);
  logic arm_q = 1'b0;
  logic cs_q = 1'b0;
  logic sclk_q = 1'b0;
  logic mosi_q = 1'b0;
  // separate byte port; clocks idle low when unselected
  assign cs_a_o = cs_q & arm_q;
  assign cs_d_o = cs_q & !arm_q;
  assign sclk_a_o = sclk_q & arm_q;
  assign sclk_o = sclk_q & !arm_q;
  assign mosi_a_o = mosi_q;
  assign mosi_o = mosi_q;
  // n clocks, each level held several core cycles
  task automatic xfer(input logic arm, input logic [15:0] w, input int n,
    output logic [15:0] rx);
    int bits;
    bits = arm ? 8 : 16;
    rx = '0;
    arm_q <= arm;
    @(posedge core_clk_i);
    cs_q <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    for (int k = 0; k < n; k++)
    begin
      mosi_q <= w[bits - 1 - (k % bits)]; // msb first, mode on top
      repeat (5) @(posedge core_clk_i);
      @(negedge core_clk_i);
      rx = {rx[14:0], arm ? miso_a_i : miso_i};
      @(posedge core_clk_i);
      sclk_q <= 1'b1;
      repeat (4) @(posedge core_clk_i);
      sclk_q <= 1'b0;
    end
    repeat (4) @(posedge core_clk_i);
    cs_q <= 1'b0;
    mosi_q <= ~mosi_q;
    repeat (8) @(posedge core_clk_i);
    @(negedge core_clk_i);
  endtask
endmodule

// ---- tb/sqdc_tb_top.sv ----
// testbench for the squib arming and deploy control block
`timescale 1ns/1ps
module sqdc_tb_top;
  import sqdc_pkg::*;
  localparam int DEP = 1200;
  localparam int PST = 1000;
  localparam int GL = 4;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic deploy_enable_pin_i = 1'b0;
  logic sclk_a_i, cs_a_i, mosi_a_i, sclk_i, cs_d_i, mosi_i;
  logic miso_a_o, miso_a_oe_o, miso_o, miso_oe_o;
  logic [SQDC_NCH-1:0] high_side_output_o, low_side_output_o, isrc_en_o, isink_en_o;
  logic [SQDC_NCH-1:0] ibias_en_o, high_side_pulldown_o;
  logic [2:0] monitor_sel_o;
  logic [15:0] rx;
  logic [15:0] dw [3] = '{16'h9d87, 16'h8280, 16'h8000};
  logic [31:0] de [3] = '{32'h2020_2020, 32'h0000_0404, 32'h0};
  logic [2:0] dm [3] = '{3'h3, 3'h0, 3'h0};
  int err_count = 0;
  int cmp_count = 0;
  always #25 core_clk_i = ~core_clk_i;
  sqdc_top #(.DEPLOY_CYCLES(DEP), .PST_CYCLES(PST), .GLITCH_CYCLES(GL), .MOS_CYCLES(20))
    sqdc_top_i (.core_clk_i, .rst_i, .sclk_a_i, .cs_a_i, .mosi_a_i, .miso_a_o, .miso_a_oe_o,
    .sclk_i, .cs_d_i, .mosi_i, .miso_o, .miso_oe_o, .deploy_enable_pin_i,
    .battery_short_threshold_i(8'h00), .ground_short_threshold_i(8'h00),
    .high_side_output_o, .low_side_output_o, .isrc_en_o, .isink_en_o, .ibias_en_o,
    .high_side_pulldown_o, .monitor_sel_o);
  sqdc_host sqdc_host_i (.core_clk_i, .miso_a_i(miso_a_oe_o ? miso_a_o : 1'bz),
    .miso_i(miso_oe_o ? miso_o : 1'bz), .sclk_a_o(sclk_a_i), .cs_a_o(cs_a_i),
    .mosi_a_o(mosi_a_i), .sclk_o(sclk_i), .cs_d_o(cs_d_i), .mosi_o(mosi_i));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic drv(input logic [15:0] w);
    sqdc_host_i.xfer(1'b0, w, 16, rx);
  endtask
  task automatic arm(input logic [7:0] b, input int n);
    sqdc_host_i.xfer(1'b1, {8'h00, b}, n, rx);
  endtask
  task automatic pin(input logic v);
    @(posedge core_clk_i);
    deploy_enable_pin_i <= v;
    repeat (GL + 8) @(posedge core_clk_i);
    @(negedge core_clk_i);
  endtask
  task automatic dep_is(input logic [7:0] m);
    check({high_side_output_o, low_side_output_o}, {m, m});
  endtask
  task automatic stop_test;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (40000) @(posedge core_clk_i);
    err_count++;
    stop_test();
  end
  initial
  begin
    repeat (12) @(posedge core_clk_i);
    rst_i <= 1'b0;
    repeat (4) @(negedge core_clk_i);
    dep_is(8'h00);
    check({isrc_en_o, ibias_en_o}, 16'h0000);
    drv(16'hc000);
    check(rx, SQDC_RESP_RST);
    for (int n = 15; n <= 17; n += 2)
    begin
      sqdc_host_i.xfer(1'b0, 16'hc000, n, rx);
      drv(16'hc000);
      check(rx, SQDC_RESP_FAULT);
    end
    $display("framing test done");
    for (int i = 0; i < 3; i++)
    begin
      drv(dw[i]);
      check({isrc_en_o, isink_en_o}, de[i][31:16]);
      check({ibias_en_o, high_side_pulldown_o}, de[i][15:0]);
      check({13'h0, monitor_sel_o}, {13'h0, dm[i]});
    end
    $display("diagnostic test done");
    arm(8'h01, 8);
    pin(1'b1);
    drv(16'h4101);
    dep_is(8'h01);
    pin(1'b0);
    dep_is(8'h01);
    drv(16'h0000);
    drv(16'h4101);
    check(rx, SQDC_RESP_FAULT);
    drv(16'hc000);
    check(rx, 16'h4001);
    drv(16'hc000);
    check(rx, 16'hc001);
    dep_is(8'h01);
    // arming during the deployment must not start a timer
    arm(8'h02, 8);
    arm(8'h00, 8);
    check(rx, 16'h0000);
    repeat (DEP) @(negedge core_clk_i);
    dep_is(8'h00);
    $display("deploy test done");
    pin(1'b1);
    arm(8'h02, 8);
    repeat (PST + 20) @(negedge core_clk_i);
    drv(16'h4102);
    dep_is(8'h00);
    drv(16'h4104);
    drv(16'h4004);
    arm(8'h04, 8);
    dep_is(8'h00);
    drv(16'h4108);
    arm(8'h00, 8);
    arm(8'h08, 7);
    dep_is(8'h00);
    arm(8'h08, 8);
    dep_is(8'h08);
    @(posedge core_clk_i);
    rst_i <= 1'b1;
    repeat (3) @(negedge core_clk_i);
    dep_is(8'h00);
    @(posedge core_clk_i);
    rst_i <= 1'b0;
    repeat (4) @(negedge core_clk_i);
    drv(16'hc000);
    check(rx, SQDC_RESP_RST);
    $display("timer source test done");
    // MOS check on channel 0: low side drives with the pin high, high side stays off with it low
    drv(16'h8040);
    check({high_side_output_o, low_side_output_o}, 16'h0001);
    pin(1'b0);
    drv(16'h8020);
    check({high_side_output_o, low_side_output_o}, 16'h0000);
    drv(16'h4110);
    pin(1'b1);
    arm(8'h10, 8);
    dep_is(8'h00);
    drv(16'hc000);
    check(rx, 16'h4010);
    pin(1'b0);
    arm(8'h40, 8);
    // short pin pulse that covers the edge at which the command is taken
    fork
      drv(16'h4140);
      begin
        repeat (16) @(negedge sclk_i);
        repeat (3) @(posedge core_clk_i);
        deploy_enable_pin_i <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        deploy_enable_pin_i <= 1'b0;
      end
    join
    dep_is(8'h00);
    pin(1'b1);
    drv(16'h4140);
    dep_is(8'h40);
    $display("enable pin test done");
    stop_test();
  end
endmodule
